// [design/cgsf_core.sv]
// clock generator status, loop filter and trim registers
// assumes loop status pins are asynchronous and pass the pin stage;
// registers sit on a plain strobe port, read data one cycle later
//
// Function
// - mode status reported in status bits 7:6
// - mode status lags select through synchronisation
// - status bit 5 shows chosen reference source
// - sticky lock-lost flag in status bit 4
// - lock bit, forced low outside engaged modes
// - sticky clock-lost flag in status bit 2
// - status bit 1 shows external reference ok
// - irq flag cleared by read then write one
// - new interrupt restarts the clearing sequence
// - writing zero to irq flag does nothing
// - osc stable after two good samples, not static
// - osc stable gates off exit for engaged selects, and monitoring
// - osc stable cleared on entering off state
// - 12-bit filter writable only when select is 00
// - upper filter write loads whole 12-bit value
// - upper write ignored while latch still pending
// - trim adjusts reference period by 25 percent
// - trim binary weighted, higher means longer
// - trim kept across system reset
// - lock-loss reset enable picks irq or reset
// - clock-loss reset enable picks irq or reset
// - select codes match the status mode codes
`timescale 1ns/1ns
module cgsf_core
#(
  parameter int LATCH_CYC = 2
)
(
  // clock and resets
  input  wire logic                 CLK,
  input  wire logic                 SRST,
  input  wire logic                 PORST,
  // register port
  input  wire cgsf_pkg::cgsf_addr_t ADDR,
  input  wire cgsf_pkg::cgsf_byte_t WDATA,
  input  wire logic                 WR,
  input  wire logic                 RD,
  output logic [7:0]                RDATA,
  // loop status pins
  input  wire logic                 FLL_LOCK,
  input  wire logic                 CLK_LOST,
  input  wire logic                 EXT_REF_OK,
  input  wire logic                 REF_IS_XTAL,
  input  wire logic                 OSC_NOT_STATIC,
  input  wire logic                 ERR_IN_RANGE,
  input  wire logic                 ERR_SAMPLE_TGL,
  input  wire logic                 OFF_REQ,
  // outputs to the clock generator
  output logic [1:0]                MODE_STATUS,
  output logic [11:0]               FILTER_VALUE,
  output logic [7:0]                TRIM_VALUE,
  output logic                      OSC_STABLE,
  output logic                      OSC_MON_EN,
  output logic                      IRQ_PENDING,
  output logic                      RESET_REQ
);
  import cgsf_pkg::*;

  typedef enum logic [1:0] {ST_RUN, ST_OFF, ST_WAIT} cgsf_state_t;
  localparam int CNT_W = $clog2(LATCH_CYC + 1);
  localparam logic [CNT_W-1:0] CNT_0 = '0;
  localparam logic [CNT_W-1:0] CNT_1 = CNT_W'(1);
  localparam logic [CNT_W-1:0] CNT_LATCH = CNT_W'(LATCH_CYC);

  generate
    if (LATCH_CYC < 1)
    begin : g_chk
      $error("cgsf_core LATCH_CYC must be at least 1");
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////
  // decode helpers

  function automatic logic hit(input logic stb, input cgsf_addr_t a,
                               input cgsf_addr_t ofs);
    hit = stb && (a == ofs);
  endfunction

  function automatic logic is_engaged(input cgsf_mode_t m);
    is_engaged = (m == MODE_FEI) || (m == MODE_FEE);
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // pin synchronisation

  cgsf_fll_if fll ();

  cgsf_pin_sync #(.W(PIN_N)) u_sync
  (
    .clk  (CLK),
    .srst (SRST),
    .pins ({OFF_REQ, ERR_SAMPLE_TGL, ERR_IN_RANGE, OSC_NOT_STATIC,
            REF_IS_XTAL, EXT_REF_OK, CLK_LOST, FLL_LOCK}),
    .fll  (fll)
  );

  ////////////////////////////////////////////////////////////////////////
  // state

  cgsf_state_t      state_q;
  cgsf_mode_t       sel_q;
  cgsf_mode_t       sel_s1_q;
  cgsf_mode_t       sel_s2_q;
  cgsf_mode_t       mode_q;
  logic             lock_loss_reset_en_q;
  logic             clock_loss_reset_en_q;
  logic             lock_q;
  logic             lock_lost_flag_q;
  logic             clock_lost_flag_q;
  logic             ext_ref_ok_q;
  logic             ref_source_status_q;
  logic             irq_q;
  logic             arm_q;
  logic             clk_lost_prev_q;
  logic             samp_prev_q;
  logic [1:0]       good_q;
  logic [1:0]       good_d;
  logic             osc_q;
  logic             osc_mon_q;
  logic [11:0]      flt_q;
  logic [7:0]       flt_lo_q;
  logic [CNT_W-1:0] latch_q;
  logic [7:0]       trim_q;
  logic             rst_req_q;
  logic [7:0]       rdata_q;
  cgsf_mode_t       target;
  logic             lol_evt;
  logic             loc_evt;
  logic             irq_set;
  logic             irq_clr;
  logic             samp;
  logic             scm_sel;

  assign scm_sel = (sel_q == MODE_SCM);
  assign samp    = fll.samp_tgl ^ samp_prev_q;

  ////////////////////////////////////////////////////////////////////////
  // control registers

  always_ff @(posedge CLK)
  begin
    if (SRST)
    begin
      sel_q   <= MODE_SCM;
      lock_loss_reset_en_q <= 1'b0;
      clock_loss_reset_en_q <= 1'b0;
    end
    else
    begin
      if (hit(WR, ADDR, OFS_CTRL1))
        sel_q <= WDATA[B_SEL_HI:B_SEL_LO];
      if (hit(WR, ADDR, OFS_CTRL2))
      begin
        lock_loss_reset_en_q <= WDATA[B_LOCK_LOSS_RESET_EN];
        clock_loss_reset_en_q <= WDATA[B_CLOCK_LOSS_RESET_EN];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // mode sequencing

  // select passes two stages before the status may follow it
  always_ff @(posedge CLK)
  begin
    if (SRST)
    begin
      sel_s1_q <= MODE_SCM;
      sel_s2_q <= MODE_SCM;
    end
    else
    begin
      sel_s1_q <= sel_q;
      sel_s2_q <= sel_s1_q;
    end
  end

  always_comb
  begin
    target = sel_s2_q;
    // bypass waits for a valid external reference
    if ((sel_s2_q == MODE_FBE) && !fll.ext_ok)
      target = MODE_SCM;
    if ((sel_s2_q == MODE_FEE) && !(fll.ext_ok && osc_q))
      target = MODE_SCM;
  end

  always_ff @(posedge CLK)
  begin
    if (SRST)
    begin
      state_q <= ST_RUN;
      mode_q  <= MODE_SCM;
    end
    else
    begin
      unique case (state_q)
        ST_RUN:
        begin
          if (fll.off_req)
            state_q <= ST_OFF;
          else
            mode_q <= target;
        end
        ST_OFF:
        begin
          if (!fll.off_req)
          begin
            // engaged request idles self-clocked until osc settles
            state_q <= sel_q[0] ? ST_WAIT : ST_RUN;
            mode_q  <= MODE_SCM;
          end
        end
        ST_WAIT:
        begin
          if (fll.off_req)
            state_q <= ST_OFF;
          else if (osc_q)
            state_q <= ST_RUN;
          mode_q <= MODE_SCM;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // lock, loss events and reference status

  // loss of lock counts only when the mode did not move on purpose
  assign lol_evt = lock_q && !fll.lock && (state_q == ST_RUN)
                   && is_engaged(mode_q) && (sel_s2_q == mode_q);
  assign loc_evt = fll.clk_lost && !clk_lost_prev_q;
  assign irq_set = (lol_evt && !lock_loss_reset_en_q) || (loc_evt && !clock_loss_reset_en_q);
  assign irq_clr = hit(WR, ADDR, OFS_STAT1) && WDATA[B_IRQ] && arm_q;

  always_ff @(posedge CLK)
  begin
    if (SRST)
    begin
      lock_q          <= 1'b0;
      ext_ref_ok_q          <= 1'b0;
      ref_source_status_q         <= 1'b0;
      clk_lost_prev_q <= 1'b0;
    end
    else
    begin
      lock_q <= fll.lock && (state_q == ST_RUN)
                && is_engaged(mode_q);
      ext_ref_ok_q          <= fll.ext_ok;
      ref_source_status_q         <= fll.ref_xtal;
      clk_lost_prev_q <= fll.clk_lost;
    end
  end

  // sticky flags, write one clears, a new event wins over the clear
  always_ff @(posedge CLK)
  begin
    if (SRST)
    begin
      lock_lost_flag_q <= 1'b0;
      clock_lost_flag_q <= 1'b0;
    end
    else
    begin
      if (lol_evt)
        lock_lost_flag_q <= 1'b1;
      else if (hit(WR, ADDR, OFS_STAT1) && WDATA[B_LOCK_LOST_FLAG])
        lock_lost_flag_q <= 1'b0;
      if (loc_evt)
        clock_lost_flag_q <= 1'b1;
      else if (hit(WR, ADDR, OFS_STAT1) && WDATA[B_CLOCK_LOST_FLAG])
        clock_lost_flag_q <= 1'b0;
    end
  end

  always_ff @(posedge CLK)
  begin
    if (SRST)
      rst_req_q <= 1'b0;
    else
      rst_req_q <= (lol_evt && lock_loss_reset_en_q)
                   || (loc_evt && clock_loss_reset_en_q);
  end

  ////////////////////////////////////////////////////////////////////////
  // interrupt flag and its clearing sequence

  always_ff @(posedge CLK)
  begin
    if (SRST)
      irq_q <= 1'b0;
    else if (irq_set)
      irq_q <= 1'b1;
    else if (irq_clr)
      irq_q <= 1'b0;
  end

  always_ff @(posedge CLK)
  begin
    if (SRST)
      arm_q <= 1'b0;
    else if (irq_set)
      arm_q <= 1'b0;
    else if (irq_clr)
      arm_q <= 1'b0;
    else if (hit(RD, ADDR, OFS_STAT1) && irq_q)
      arm_q <= 1'b1;
  end

  ////////////////////////////////////////////////////////////////////////
  // oscillator stable detection

  always_comb
  begin
    good_d = good_q;
    if (samp)
    begin
      if (!fll.err_ok)
        good_d = 2'h0;
      else if (good_q != OSC_GOOD_N)
        good_d = good_q + 2'h1;
    end
  end

  always_ff @(posedge CLK)
  begin
    if (SRST)
    begin
      samp_prev_q <= 1'b0;
      good_q      <= 2'h0;
      osc_q       <= 1'b0;
      osc_mon_q   <= 1'b0;
    end
    else
    begin
      samp_prev_q <= fll.samp_tgl;
      if (fll.off_req || (state_q == ST_OFF) || !fll.not_static)
      begin
        good_q <= 2'h0;
        osc_q  <= 1'b0;
      end
      else
      begin
        good_q <= good_d;
        osc_q  <= (good_d == OSC_GOOD_N);
      end
      osc_mon_q <= osc_q && (state_q == ST_RUN)
                   && (mode_q == MODE_SCM);
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // loop filter

  always_ff @(posedge CLK)
  begin
    if (SRST)
      flt_lo_q <= FLT_RST[FLT_LO_W-1:0];
    else if (hit(WR, ADDR, OFS_FLTL) && scm_sel)
      flt_lo_q <= WDATA;
  end

  // latch window models the transfer into the oscillator domain
  always_ff @(posedge CLK)
  begin
    if (SRST)
    begin
      flt_q   <= FLT_RST;
      latch_q <= CNT_0;
    end
    else
    begin
      if (latch_q != CNT_0)
        latch_q <= latch_q - CNT_1;
      if (hit(WR, ADDR, OFS_FLTU) && scm_sel
          && (latch_q == CNT_0))
      begin
        // lower byte must already be staged by software
        flt_q   <= {WDATA[FLT_W-FLT_LO_W-1:0], flt_lo_q};
        latch_q <= CNT_LATCH;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // trim, reset only at power-on so a system reset keeps it

  always_ff @(posedge CLK)
  begin
    if (PORST)
      trim_q <= TRIM_RST;
    else if (hit(WR, ADDR, OFS_TRIM))
      trim_q <= WDATA;
  end

  ////////////////////////////////////////////////////////////////////////
  // read port

  always_ff @(posedge CLK)
  begin
    if (SRST)
      rdata_q <= BYTE_0;
    else if (RD)
    begin
      rdata_q <= BYTE_0;
      case (ADDR)
        OFS_STAT1:
        begin
          rdata_q[B_MODE_HI:B_MODE_LO] <= mode_q;
          rdata_q[B_REF_SOURCE_STATUS]             <= ref_source_status_q;
          rdata_q[B_LOCK_LOST_FLAG]              <= lock_lost_flag_q;
          rdata_q[B_LOCK]              <= lock_q;
          rdata_q[B_CLOCK_LOST_FLAG]              <= clock_lost_flag_q;
          rdata_q[B_EXT_REF_OK]              <= ext_ref_ok_q;
          rdata_q[B_IRQ]               <= irq_q;
        end
        OFS_STAT2:
          rdata_q[B_OSCST] <= osc_q;
        OFS_FLTU:
          rdata_q[FLT_W-FLT_LO_W-1:0] <= flt_q[FLT_W-1:FLT_LO_W];
        OFS_FLTL:
          rdata_q <= flt_q[FLT_LO_W-1:0];
        OFS_TRIM:
          rdata_q <= trim_q;
        OFS_CTRL1:
          rdata_q[B_SEL_HI:B_SEL_LO] <= sel_q;
        OFS_CTRL2:
        begin
          rdata_q[B_LOCK_LOSS_RESET_EN] <= lock_loss_reset_en_q;
          rdata_q[B_CLOCK_LOSS_RESET_EN] <= clock_loss_reset_en_q;
        end
        default:
          rdata_q <= BYTE_0;
      endcase
    end
    else
      rdata_q <= BYTE_0;
  end

  ////////////////////////////////////////////////////////////////////////
  // outputs

  assign RDATA        = rdata_q;
  assign MODE_STATUS  = mode_q;
  assign FILTER_VALUE = flt_q;
  assign TRIM_VALUE   = trim_q;
  assign OSC_STABLE   = osc_q;
  assign OSC_MON_EN   = osc_mon_q;
  assign IRQ_PENDING  = irq_q;
  assign RESET_REQ    = rst_req_q;

endmodule

// [design/cgsf_pkg.sv]
// constants for the clock generator status, filter and trim block
// assumes an 8-bit register port with a 3-bit word address
package cgsf_pkg;

  typedef logic [2:0] cgsf_addr_t;
  typedef logic [7:0] cgsf_byte_t;
  typedef logic [1:0] cgsf_mode_t;

  // register offsets
  localparam cgsf_addr_t OFS_STAT1 = 3'h0;
  localparam cgsf_addr_t OFS_STAT2 = 3'h1;
  localparam cgsf_addr_t OFS_FLTU  = 3'h2;
  localparam cgsf_addr_t OFS_FLTL  = 3'h3;
  localparam cgsf_addr_t OFS_TRIM  = 3'h4;
  localparam cgsf_addr_t OFS_CTRL1 = 3'h5;
  localparam cgsf_addr_t OFS_CTRL2 = 3'h6;

  // primary status fields
  localparam int B_MODE_HI = 7;
  localparam int B_MODE_LO = 6;
  localparam int B_REF_SOURCE_STATUS   = 5;
  localparam int B_LOCK_LOST_FLAG    = 4;
  localparam int B_LOCK    = 3;
  localparam int B_CLOCK_LOST_FLAG    = 2;
  localparam int B_EXT_REF_OK    = 1;
  localparam int B_IRQ     = 0;
  // secondary status
  localparam int B_OSCST   = 0;
  // control fields
  localparam int B_SEL_HI  = 4;
  localparam int B_SEL_LO  = 3;
  localparam int B_LOCK_LOSS_RESET_EN   = 7;
  localparam int B_CLOCK_LOSS_RESET_EN   = 3;

  // mode codes, shared by select and status
  localparam cgsf_mode_t MODE_SCM = 2'h0;
  localparam cgsf_mode_t MODE_FEI = 2'h1;
  localparam cgsf_mode_t MODE_FBE = 2'h2;
  localparam cgsf_mode_t MODE_FEE = 2'h3;

  // filter layout
  localparam int FLT_W    = 12;
  localparam int FLT_LO_W = 8;
  localparam logic [11:0] FLT_RST  = 12'h000;
  localparam cgsf_byte_t  TRIM_RST = 8'h80;
  localparam cgsf_byte_t  BYTE_0   = 8'h00;

  // good samples needed before the oscillator counts as stable
  localparam logic [1:0] OSC_GOOD_N = 2'h2;

  // pin indices into the synchroniser vector
  localparam int PIN_LOCK  = 0;
  localparam int PIN_CLKL  = 1;
  localparam int PIN_EXTOK = 2;
  localparam int PIN_XTAL  = 3;
  localparam int PIN_NSTAT = 4;
  localparam int PIN_ERROK = 5;
  localparam int PIN_SAMP  = 6;
  localparam int PIN_OFF   = 7;
  localparam int PIN_N     = 8;

endpackage

// [design/cgsf_fll_if.sv]
// synchronised loop status signals between pin stage and core
// assumes both ends share one clock
`timescale 1ns/1ns
interface cgsf_fll_if;
  logic lock;
  logic clk_lost;
  logic ext_ok;
  logic ref_xtal;
  logic not_static;
  logic err_ok;
  logic samp_tgl;
  logic off_req;

  modport src (output lock, clk_lost, ext_ok, ref_xtal, not_static,
               err_ok, samp_tgl, off_req);
  modport dst (input lock, clk_lost, ext_ok, ref_xtal, not_static,
               err_ok, samp_tgl, off_req);
endinterface

// [design/cgsf_pin_sync.sv]
// three-stage synchroniser for the loop status pins
// assumes pins are asynchronous to CLK; output moves when stages 2, 3 agree
`timescale 1ns/1ns
module cgsf_pin_sync
#(
  parameter int W = cgsf_pkg::PIN_N
)
(
  // clock and reset
  input  wire logic         clk,
  input  wire logic         srst,
  // raw pins
  input  wire logic [W-1:0] pins,
  // synchronised view
  cgsf_fll_if.src           fll
);
  import cgsf_pkg::*;

  logic [W-1:0] s1_q;
  logic [W-1:0] s2_q;
  logic [W-1:0] s3_q;
  logic [W-1:0] q_q;

  generate
    if (W != PIN_N)
    begin : g_chk
      $error("cgsf_pin_sync width must match pin count");
    end
  endgenerate

  genvar i;
  generate
    for (i = 0; i < W; i++)
    begin : g_bit
      always_ff @(posedge clk)
      begin
        if (srst)
        begin
          s1_q[i] <= 1'b0;
          s2_q[i] <= 1'b0;
          s3_q[i] <= 1'b0;
          q_q[i]  <= 1'b0;
        end
        else
        begin
          s1_q[i] <= pins[i];
          s2_q[i] <= s1_q[i];
          s3_q[i] <= s2_q[i];
          // glitch filter: a level counts only once it held two samples
          if (s2_q[i] == s3_q[i])
            q_q[i] <= s3_q[i];
        end
      end
    end
  endgenerate

  assign fll.lock       = q_q[PIN_LOCK];
  assign fll.clk_lost   = q_q[PIN_CLKL];
  assign fll.ext_ok     = q_q[PIN_EXTOK];
  assign fll.ref_xtal   = q_q[PIN_XTAL];
  assign fll.not_static = q_q[PIN_NSTAT];
  assign fll.err_ok     = q_q[PIN_ERROK];
  assign fll.samp_tgl   = q_q[PIN_SAMP];
  assign fll.off_req    = q_q[PIN_OFF];

endmodule

// [tb/cgsf_core_sva.sv]
// checker for the status, filter and trim registers
// assumes bind onto cgsf_core, one clock CLK, sync reset SRST
`timescale 1ns/1ns
module cgsf_core_sva
#(
  parameter int LATCH_CYC = 2
)
(
  // clock and resets
  input wire logic                 CLK,
  input wire logic                 SRST,
  input wire logic                 PORST,
  // register port
  input wire cgsf_pkg::cgsf_addr_t ADDR,
  input wire cgsf_pkg::cgsf_byte_t WDATA,
  input wire logic                 WR,
  input wire logic                 RD,
  input wire logic [7:0]           RDATA,
  // pins and outputs
  input wire logic                 OFF_REQ,
  input wire logic [1:0]           MODE_STATUS,
  input wire logic [11:0]          FILTER_VALUE,
  input wire logic [7:0]           TRIM_VALUE,
  input wire logic                 OSC_STABLE,
  input wire logic                 OSC_MON_EN,
  input wire logic                 IRQ_PENDING,
  input wire logic                 RESET_REQ
);
  import cgsf_pkg::*;

  logic [3:0] gap_q;
  wire        rd_st1 = RD && ADDR == OFS_STAT1;

  default clocking cb @(posedge CLK);
  endclocking
  default disable iff (SRST);

  ////////////////////////////////////////////////////////////
  // cycles since the filter last moved, saturating
  always_ff @(posedge CLK)
  begin
    if (SRST)
      gap_q <= 4'hF;
    else if ($changed(FILTER_VALUE))
      gap_q <= 4'h0;
    else if (gap_q != 4'hF)
      gap_q <= gap_q + 4'h1;
  end

  ////////////////////////////////////////////////////////////
  mode_read_a: assert property (rd_st1 |=>
    RDATA[7:6] == $past(MODE_STATUS))
    else $error("mode field differs from mode output");
  mode_lag_a: assert property (WR && ADDR == OFS_CTRL1 |=>
    $stable(MODE_STATUS))
    else $error("mode moved right after select write");
  lock_gate_a: assert property (rd_st1 && !MODE_STATUS[0] |=> !RDATA[3])
    else $error("lock bit set outside engaged modes");
  irq_read_a: assert property (rd_st1 |=>
    RDATA[0] == $past(IRQ_PENDING))
    else $error("irq bit differs from pending output");
  irq_clear_a: assert property ($fell(IRQ_PENDING) |->
    $past(WR && ADDR == OFS_STAT1 && WDATA[0]))
    else $error("irq cleared without a write of one");
  irq_keep_a: assert property (IRQ_PENDING && WR && ADDR == OFS_STAT1
    && !WDATA[0] |=> IRQ_PENDING)
    else $error("irq cleared by a write of zero");
  filt_src_a: assert property ($changed(FILTER_VALUE) |->
    $past(WR && ADDR == OFS_FLTU))
    else $error("filter moved without upper write");
  filt_gap_a: assert property ($changed(FILTER_VALUE) |->
    gap_q >= LATCH_CYC)
    else $error("filter reloaded while latch pending");
  trim_write_a: assert property (WR && ADDR == OFS_TRIM && !PORST |=>
    TRIM_VALUE == $past(WDATA))
    else $error("trim write not taken");
  trim_keep_a: assert property (@(posedge CLK) disable iff (PORST)
    $changed(TRIM_VALUE) |-> $past(WR && ADDR == OFS_TRIM))
    else $error("trim changed without a write");
  rst_pulse_a: assert property (RESET_REQ |=> !RESET_REQ)
    else $error("reset request longer than one cycle");
  mon_gate_a: assert property (OSC_MON_EN |->
    OSC_STABLE || $past(OSC_STABLE))
    else $error("monitoring without stable oscillator");
  osc_off_a: assert property (OFF_REQ [*7] |-> !OSC_STABLE)
    else $error("osc stable kept in off state");
endmodule

bind cgsf_core cgsf_core_sva #(.LATCH_CYC(LATCH_CYC)) u_sva
(
  .CLK(CLK), .SRST(SRST), .PORST(PORST), .ADDR(ADDR), .WDATA(WDATA),
  .WR(WR), .RD(RD), .RDATA(RDATA), .OFF_REQ(OFF_REQ),
  .MODE_STATUS(MODE_STATUS), .FILTER_VALUE(FILTER_VALUE),
  .TRIM_VALUE(TRIM_VALUE), .OSC_STABLE(OSC_STABLE),
  .OSC_MON_EN(OSC_MON_EN), .IRQ_PENDING(IRQ_PENDING),
  .RESET_REQ(RESET_REQ)
);

// [tb/cgsf_core_test.sv]
// self-checking bench for the status, filter and trim registers
// assumes cgsf_core with checker bound; bench drives every pin itself
`timescale 1ns/1ns
module cgsf_core_test;
  import cgsf_pkg::*;

  logic        CLK, SRST, PORST, WR, RD;
  cgsf_addr_t  ADDR;
  cgsf_byte_t  WDATA, rdv, lo, hi, tv;
  logic [7:0]  RDATA, TRIM_VALUE;
  logic        FLL_LOCK, CLK_LOST, EXT_REF_OK, REF_IS_XTAL;
  logic        OSC_NOT_STATIC, ERR_IN_RANGE, ERR_SAMPLE_TGL, OFF_REQ;
  logic [1:0]  MODE_STATUS;
  logic [11:0] FILTER_VALUE, fv;
  logic        OSC_STABLE, OSC_MON_EN, IRQ_PENDING, RESET_REQ;
  cgsf_mode_t  prev;
  cgsf_mode_t  mseq [4] = '{MODE_FEI, MODE_FBE, MODE_FEE, MODE_SCM};
  int          n_errors, checked, seed;

  cgsf_core uut
  (
    .CLK(CLK), .SRST(SRST), .PORST(PORST), .ADDR(ADDR), .WDATA(WDATA),
    .WR(WR), .RD(RD), .RDATA(RDATA), .FLL_LOCK(FLL_LOCK),
    .CLK_LOST(CLK_LOST), .EXT_REF_OK(EXT_REF_OK),
    .REF_IS_XTAL(REF_IS_XTAL), .OSC_NOT_STATIC(OSC_NOT_STATIC),
    .ERR_IN_RANGE(ERR_IN_RANGE), .ERR_SAMPLE_TGL(ERR_SAMPLE_TGL),
    .OFF_REQ(OFF_REQ), .MODE_STATUS(MODE_STATUS),
    .FILTER_VALUE(FILTER_VALUE), .TRIM_VALUE(TRIM_VALUE),
    .OSC_STABLE(OSC_STABLE), .OSC_MON_EN(OSC_MON_EN),
    .IRQ_PENDING(IRQ_PENDING), .RESET_REQ(RESET_REQ)
  );

  initial
  begin
    CLK = 1'b0;
    forever #25 CLK = ~CLK;
  end

  ////////////////////////////////////////////////////////////
  // f packs lock-lost, lock, clock-lost, irq
  function automatic cgsf_byte_t st1(cgsf_mode_t m, logic r, logic e,
                                     logic [3:0] f);
    return {m, r, f[3], f[2], f[1], e, f[0]};
  endfunction

  task automatic chk(string nm, logic [11:0] e, logic [11:0] g);
    checked++;
    if (g !== e)
    begin
      n_errors++;
      $display("BAD %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic tick(int n);
    repeat (n) @(posedge CLK);
    #1;
  endtask

  task automatic idle(int n);
    WR <= 1'b0;
    RD <= 1'b0;
    tick(n);
  endtask

  // strobe left high so writes may follow back to back
  task automatic wr(cgsf_addr_t a, cgsf_byte_t d);
    ADDR  <= a;
    WDATA <= d;
    WR    <= 1'b1;
    RD    <= 1'b0;
    tick(1);
  endtask

  task automatic rdc(string nm, cgsf_addr_t a, cgsf_byte_t e);
    ADDR <= a;
    RD   <= 1'b1;
    WR   <= 1'b0;
    tick(1);
    RD   <= 1'b0;
    rdv = RDATA;
    chk(nm, {4'h0, e}, {4'h0, rdv});
    tick(1);
  endtask

  task automatic samples(int n);
    repeat (n)
    begin
      ERR_SAMPLE_TGL <= ~ERR_SAMPLE_TGL;
      tick(8);
    end
  endtask

  task automatic see_reset(string nm);
    int k;
    k = 0;
    while (RESET_REQ !== 1'b1 && k < 12)
    begin
      tick(1);
      k++;
    end
    chk(nm, 12'h001, {11'h0, RESET_REQ});
  endtask

  task automatic complete_run();
    $display("checked %0d n_errors %0d", checked, n_errors);
    if (n_errors == 0 && checked > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////
  initial
  begin
    {SRST, PORST, WR, RD, ADDR, WDATA} = {2'b11, 2'b00, 3'h0, 8'h00};
    {FLL_LOCK, CLK_LOST, EXT_REF_OK, REF_IS_XTAL} = 4'b0011;
    {OSC_NOT_STATIC, ERR_IN_RANGE, ERR_SAMPLE_TGL, OFF_REQ} = 4'b0000;
    n_errors = 0;
    checked = 0;
    seed = $urandom(60822);
    tick(16);
    SRST  <= 1'b0;
    PORST <= 1'b0;
    tick(1);
    chk("trim out", {4'h0, TRIM_RST}, {4'h0, TRIM_VALUE});
    rdc("unmapped", 3'h7, BYTE_0);
    rdc("status2", OFS_STAT2, BYTE_0);
    for (int i = 0; i < 2; i++)
    begin
      REF_IS_XTAL <= i[0];
      EXT_REF_OK  <= ~i[0];
      tick(8);
      rdc("status1", OFS_STAT1, st1(MODE_SCM, i[0], ~i[0], 4'h0));
    end
    repeat (3)
    begin
      tv = 8'($urandom_range(255));
      wr(OFS_TRIM, tv);
      idle(1);
      chk("trim out", {4'h0, tv}, {4'h0, TRIM_VALUE});
      rdc("trim reg", OFS_TRIM, tv);
    end
    repeat (3)
    begin
      lo = 8'($urandom);
      hi = 8'($urandom);
      fv = {hi[3:0], lo};
      wr(OFS_FLTL, lo);
      wr(OFS_FLTU, hi);
      wr(OFS_FLTU, ~hi);
      idle(2);
      chk("filter", fv, FILTER_VALUE);
      rdc("filter upper", OFS_FLTU, {4'h0, hi[3:0]});
      rdc("filter lower", OFS_FLTL, lo);
    end
    SRST <= 1'b1;
    tick(2);
    SRST <= 1'b0;
    tick(1);
    chk("trim kept", {4'h0, tv}, {4'h0, TRIM_VALUE});
    chk("filter reset", FLT_RST, FILTER_VALUE);
    EXT_REF_OK     <= 1'b1;
    OSC_NOT_STATIC <= 1'b1;
    ERR_IN_RANGE   <= 1'b1;
    tick(8);
    samples(1);
    chk("osc one sample", 12'h000, {11'h0, OSC_STABLE});
    samples(1);
    rdc("status2", OFS_STAT2, 8'h01);
    chk("osc monitor", 12'h001, {11'h0, OSC_MON_EN});
    prev = MODE_SCM;
    foreach (mseq[j])
    begin
      wr(OFS_CTRL1, {3'h0, mseq[j], 3'h0});
      idle(1);
      chk("mode lag", {10'h0, prev}, {10'h0, MODE_STATUS});
      tick(8);
      chk("mode", {10'h0, mseq[j]}, {10'h0, MODE_STATUS});
      rdc("status1", OFS_STAT1, st1(mseq[j], 1'b1, 1'b1, 4'h0));
      wr(OFS_FLTL, 8'hA5);
      wr(OFS_FLTU, 8'h0C);
      idle(3);
      fv = (mseq[j] == MODE_SCM) ? 12'hCA5 : FLT_RST;
      chk("filter gate", fv, FILTER_VALUE);
      prev = mseq[j];
    end
    wr(OFS_CTRL2, BYTE_0);
    wr(OFS_CTRL1, 8'h08);
    idle(8);
    FLL_LOCK <= 1'b1;
    tick(8);
    rdc("locked", OFS_STAT1, st1(MODE_FEI, 1'b1, 1'b1, 4'h4));
    FLL_LOCK <= 1'b0;
    tick(8);
    rdc("lock lost", OFS_STAT1, st1(MODE_FEI, 1'b1, 1'b1, 4'h9));
    wr(OFS_STAT1, BYTE_0);
    idle(1);
    chk("irq write zero", 12'h001, {11'h0, IRQ_PENDING});
    CLK_LOST <= 1'b1;
    tick(8);
    wr(OFS_STAT1, 8'h01);
    idle(1);
    chk("irq restart", 12'h001, {11'h0, IRQ_PENDING});
    rdc("clock lost", OFS_STAT1, st1(MODE_FEI, 1'b1, 1'b1, 4'hB));
    wr(OFS_STAT1, 8'h15);
    idle(1);
    chk("irq clear", 12'h000, {11'h0, IRQ_PENDING});
    rdc("flags clear", OFS_STAT1, st1(MODE_FEI, 1'b1, 1'b1, 4'h0));
    CLK_LOST <= 1'b0;
    FLL_LOCK <= 1'b1;
    wr(OFS_CTRL2, 8'h88);
    idle(8);
    FLL_LOCK <= 1'b0;
    see_reset("lock loss reset");
    tick(2);
    CLK_LOST <= 1'b1;
    see_reset("clock loss reset");
    tick(2);
    chk("no irq", 12'h000, {11'h0, IRQ_PENDING});
    OFF_REQ <= 1'b1;
    tick(8);
    chk("osc off", 12'h000, {11'h0, OSC_STABLE});
    OFF_REQ <= 1'b0;
    tick(8);
    chk("off exit", {10'h0, MODE_SCM}, {10'h0, MODE_STATUS});
    samples(2);
    tick(4);
    chk("off done", {10'h0, MODE_FEI}, {10'h0, MODE_STATUS});
    complete_run();
  end

  initial
  begin
    repeat (4000) @(posedge CLK);
    n_errors++;
    complete_run();
  end
endmodule
